// [core/red_pkg.sv]
// constants, register map and types of the strength and energy readout
package red_pkg;
	// clock period of the core clock
	localparam int CLK_PERIOD_NS = 40;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_STRENGTH_STATUS = 8'h06;
	localparam logic [7:0] IDX_ENERGY_LEVEL = 8'h07;
	localparam logic [7:0] IDX_SYNC_CTRL = 8'h15;

	// field positions
	localparam int STAT_CRC_BIT = 7;
	localparam int STAT_RND_LSB = 5;
	localparam int STAT_STRENGTH_MSB = 4;
	localparam int SYNC_PDT_DIS_BIT = 7;

	// reset values
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] ENERGY_RESET = 8'hFF;
	localparam logic [7:0] SYNC_CTRL_RESET = 8'h00;

	// strength scale: 3 dB per step, saturating at 87 dB above the floor
	localparam logic [4:0] STRENGTH_MAX = 5'h1C;
	localparam logic [7:0] STRENGTH_SPAN_DB = 8'h57;
	localparam logic [7:0] DB_PER_STEP = 8'h03;
	// energy scale: largest code that a measurement can produce
	localparam logic [7:0] ENERGY_MAX = 8'h54;

	// strength refresh intervals in microseconds, per phy mode
	localparam int REFRESH_US_BPSK20 = 32;
	localparam int REFRESH_US_BPSK40 = 24;
	localparam int REFRESH_US_OQPSK = 8;
	localparam int REFRESH_CYC_BPSK20 = REFRESH_US_BPSK20 * 1000 / CLK_PERIOD_NS;
	localparam int REFRESH_CYC_BPSK40 = REFRESH_US_BPSK40 * 1000 / CLK_PERIOD_NS;
	localparam int REFRESH_CYC_OQPSK = REFRESH_US_OQPSK * 1000 / CLK_PERIOD_NS;

	// symbol periods in microseconds and symbols per energy window
	localparam int SYM_US_BPSK20 = 50;
	localparam int SYM_US_BPSK40 = 25;
	localparam int SYM_US_OQPSK = 16;
	localparam int ED_SYMS_STD = 8;
	localparam int ED_SYMS_HDR = 2;
	localparam int ED_WIN_CYC_BPSK20 = ED_SYMS_STD * SYM_US_BPSK20 * 1000 / CLK_PERIOD_NS;
	localparam int ED_WIN_CYC_BPSK40 = ED_SYMS_STD * SYM_US_BPSK40 * 1000 / CLK_PERIOD_NS;
	localparam int ED_WIN_CYC_OQPSK = ED_SYMS_STD * SYM_US_OQPSK * 1000 / CLK_PERIOD_NS;
	localparam int ED_WIN_CYC_HDR = ED_SYMS_HDR * SYM_US_OQPSK * 1000 / CLK_PERIOD_NS;

	// processing allowance after the window, longest time rounded down
	localparam int PROC_US = 12;
	localparam int PROC_CYC = PROC_US * 1000 / CLK_PERIOD_NS;
	// iterations of the serial divider
	localparam logic [4:0] DIV_STEPS = 5'h10;

	// phy mode selection from the transceiver core
	typedef enum logic [1:0] {
		RED_MODE_BPSK20 = 2'h0,
		RED_MODE_BPSK40 = 2'h1,
		RED_MODE_OQPSK = 2'h2,
		RED_MODE_HDR = 2'h3
	} red_phy_mode_e;
endpackage : red_pkg

// [core/red_strength_sampler.sv]
// periodic 5-bit received strength sampler
`timescale 1ns/10ps
module red_strength_sampler (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [1:0] phy_mode_in,
	input wire logic rx_active_in,
	input wire logic [7:0] rf_level_in,
	output logic [4:0] strength_out,
	output logic sample_out
);
	// interval timer, counts down to the next refresh
	logic [9:0] timer;
	logic [9:0] next_timer;
	logic [4:0] next_strength;
	logic next_sample;
	logic [9:0] reload;
	logic [7:0] steps;

	// refresh interval for the current mode
	always_comb begin
		unique case (red_pkg::red_phy_mode_e'(phy_mode_in))
			red_pkg::RED_MODE_BPSK20: reload = 10'(red_pkg::REFRESH_CYC_BPSK20 - 1);
			red_pkg::RED_MODE_BPSK40: reload = 10'(red_pkg::REFRESH_CYC_BPSK40 - 1);
			default: reload = 10'(red_pkg::REFRESH_CYC_OQPSK - 1);
		endcase
	end

	// timer and quantiser; power only, no signal classification
	always_comb begin
		next_timer = timer;
		next_strength = strength_out;
		next_sample = 1'b0;
		steps = rf_level_in / red_pkg::DB_PER_STEP;
		if (!rx_active_in) begin
			// outside receive the last value is held, timer rearmed
			next_timer = reload;
		end else if (timer == 10'h000) begin
			next_timer = reload;
			next_sample = 1'b1;
			// floor maps to 0, span and above saturates
			if (rf_level_in >= red_pkg::STRENGTH_SPAN_DB || steps > 8'(red_pkg::STRENGTH_MAX)) begin
				next_strength = red_pkg::STRENGTH_MAX;
			end else begin
				next_strength = steps[4:0];
			end
		end else begin
			next_timer = timer - 10'h001;
		end
	end

	// register the sampler state
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			timer <= 10'h000;
			strength_out <= 5'h00;
			sample_out <= 1'b0;
		end else begin
			timer <= next_timer;
			strength_out <= next_strength;
			sample_out <= next_sample;
		end
	end

	AST_REFRESH_SPACING: assert property (@(posedge clk_in) disable iff (rst_in)
		sample_out |=> (!sample_out)[*8])
		else $error("strength refreshed too soon");
	AST_STRENGTH_SAT: assert property (@(posedge clk_in) disable iff (rst_in)
		(rx_active_in && timer == 10'h000 && rf_level_in >= red_pkg::STRENGTH_SPAN_DB)
		|=> strength_out == red_pkg::STRENGTH_MAX)
		else $error("strength not saturated at top of range");
endmodule : red_strength_sampler

// [core/red_readout.sv]
// strength status, energy detection and apb register slave
`timescale 1ns/10ps
// What this block does
// - refresh strength at mode dependent interval
// - strength is five bits, at most 28
// - floor gives 0, floor plus 87 gives 28
// - strength sits in status bits 4:0
// - measure channel power only, no classification
// - energy averages strength over 8 symbols, 2 in HDR mode
// - energy register write in listen or busy, not auto-ack, starts manual measurement
// - manual run ends storing result, raising done
// - sync header starts silent automatic measurement
// - automatic result valid within window plus 12us
// - energy result held until next measurement ends
// - energy 0x00..0x54, 0xFF before first result
// - energy scale spans floor to floor plus 87
// - rejected manual request raises done without measuring
// - preamble detect disable blocks automatic measurements
// - status bit 7 holds frame check result
module red_readout #(
	parameter logic [13:0] ED_WIN_BPSK20 = 14'(red_pkg::ED_WIN_CYC_BPSK20),
	parameter logic [13:0] ED_WIN_BPSK40 = 14'(red_pkg::ED_WIN_CYC_BPSK40),
	parameter logic [13:0] ED_WIN_OQPSK = 14'(red_pkg::ED_WIN_CYC_OQPSK),
	parameter logic [13:0] ED_WIN_HDR = 14'(red_pkg::ED_WIN_CYC_HDR)
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [1:0] phy_mode_in,
	input wire logic rx_listen_in,
	input wire logic rx_busy_in,
	input wire logic auto_ack_receive_state_in,
	input wire logic [7:0] rf_level_in,
	input wire logic sync_header_in,
	input wire logic frame_end_event_in,
	input wire logic fcs_ok_in,
	input wire logic [1:0] random_bits_in,
	output logic measurement_done_event_out,
	output logic sync_accept_out
);
	// measurement sequencer states
	typedef enum logic [2:0] {
		RED_IDLE = 3'b001,
		RED_MEASURE = 3'b010,
		RED_DIVIDE = 3'b100
	} red_meas_state_e;

	// true when the bus address selects the word of a register index
	function automatic logic red_hit(input logic [7:0] addr, input logic [7:0] idx);
		red_hit = (addr == {idx[5:0], 2'b00});
	endfunction : red_hit

	// strength sampler outputs
	logic [4:0] strength;
	logic sample_pulse;
	// bus side state
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic preamble_detect_disable;
	logic next_pdt_dis;
	logic crc_valid;
	logic next_crc_valid;
	logic next_sync_accept;
	// decoded bus events
	logic bus_setup;
	logic bus_write;
	logic ed_write;
	logic status_write;
	// receive state qualifiers
	logic rx_any;
	logic manual_ok;
	logic sync_accept;
	// measurement state
	red_meas_state_e state;
	red_meas_state_e next_state;
	logic [13:0] win_cnt;
	logic [13:0] next_win_cnt;
	logic [13:0] win_len;
	logic [13:0] next_win_len;
	logic [15:0] sum;
	logic [15:0] next_sum;
	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic [15:0] quo;
	logic [15:0] next_quo;
	logic [15:0] rem;
	logic [15:0] next_rem;
	logic [7:0] den;
	logic [7:0] next_den;
	logic [4:0] step;
	logic [4:0] next_step;
	logic manual_pend;
	logic next_manual_pend;
	logic [7:0] energy_value_field;
	logic [7:0] next_energy;
	logic next_done;
	// combinational helpers of the sequencer
	logic [15:0] sum_add;
	logic [7:0] cnt_add;
	logic [15:0] rem_sh;
	logic [15:0] quo_sh;
	logic [13:0] mode_win;

	// the sampler runs in every receive state
	assign rx_any = rx_listen_in | rx_busy_in | auto_ack_receive_state_in;

	red_strength_sampler u_sampler (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.phy_mode_in(phy_mode_in),
		.rx_active_in(rx_any),
		.rf_level_in(rf_level_in),
		.strength_out(strength),
		.sample_out(sample_pulse)
	);

	// zero wait state slave; read data is captured in the setup phase, writes act in the access phase
	assign pready_out = 1'b1;
	assign bus_setup = psel_in & ~penable_in;
	assign bus_write = psel_in & penable_in & pwrite_in;
	assign ed_write = bus_write & red_hit(paddr_in, red_pkg::IDX_ENERGY_LEVEL);
	// status writes decode to nothing at all
	assign status_write = bus_write & red_hit(paddr_in, red_pkg::IDX_STRENGTH_STATUS);
	// manual runs only in plain listen or frame receive, not auto-ack
	assign manual_ok = (rx_listen_in | rx_busy_in) & ~auto_ack_receive_state_in;
	// header detection is suppressed while the disable bit is set
	assign sync_accept = sync_header_in & ~preamble_detect_disable & rx_any;

	// bus read mux, control register write and frame check bit
	always_comb begin
		next_prdata = prdata_out;
		next_pslverr = pslverr_out;
		next_pdt_dis = preamble_detect_disable;
		next_crc_valid = crc_valid;
		next_sync_accept = sync_accept;
		if (bus_setup) begin
			next_pslverr = 1'b0;
			next_prdata = 32'h0000_0000;
			if (red_hit(paddr_in, red_pkg::IDX_STRENGTH_STATUS)) begin
				// strength in the low field, live random bits, check flag
				next_prdata[red_pkg::STAT_CRC_BIT] = crc_valid;
				next_prdata[red_pkg::STAT_RND_LSB +: 2] = random_bits_in;
				next_prdata[red_pkg::STAT_STRENGTH_MSB:0] = strength;
			end else if (red_hit(paddr_in, red_pkg::IDX_ENERGY_LEVEL)) begin
				next_prdata[7:0] = energy_value_field;
			end else if (red_hit(paddr_in, red_pkg::IDX_SYNC_CTRL)) begin
				next_prdata[red_pkg::SYNC_PDT_DIS_BIT] = preamble_detect_disable;
			end else begin
				// unmapped word answers with an error and zero data
				next_pslverr = 1'b1;
			end
		end
		if (bus_write && red_hit(paddr_in, red_pkg::IDX_SYNC_CTRL)) begin
			next_pdt_dis = pwdata_in[red_pkg::SYNC_PDT_DIS_BIT];
		end
		// check flag drops at header detection, takes the frame check result at frame end
		if (sync_accept) begin
			next_crc_valid = 1'b0;
		end
		if (frame_end_event_in) begin
			next_crc_valid = fcs_ok_in;
		end
	end

	// register the bus side
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			prdata_out <= 32'h0000_0000;
			pslverr_out <= 1'b0;
			preamble_detect_disable <= red_pkg::SYNC_CTRL_RESET[red_pkg::SYNC_PDT_DIS_BIT];
			crc_valid <= red_pkg::STATUS_RESET[red_pkg::STAT_CRC_BIT];
			sync_accept_out <= 1'b0;
		end else begin
			prdata_out <= next_prdata;
			pslverr_out <= next_pslverr;
			preamble_detect_disable <= next_pdt_dis;
			crc_valid <= next_crc_valid;
			sync_accept_out <= next_sync_accept;
		end
	end

	// window length in cycles for the current mode
	always_comb begin
		unique case (red_pkg::red_phy_mode_e'(phy_mode_in))
			red_pkg::RED_MODE_BPSK20: mode_win = ED_WIN_BPSK20;
			red_pkg::RED_MODE_BPSK40: mode_win = ED_WIN_BPSK40;
			red_pkg::RED_MODE_OQPSK: mode_win = ED_WIN_OQPSK;
			red_pkg::RED_MODE_HDR: mode_win = ED_WIN_HDR;
		endcase
	end

	// measurement sequencer: window accumulate, then serial divide
	always_comb begin
		next_state = state;
		next_win_cnt = win_cnt;
		next_win_len = win_len;
		next_sum = sum;
		next_cnt = cnt;
		next_quo = quo;
		next_rem = rem;
		next_den = den;
		next_step = step;
		next_manual_pend = manual_pend;
		next_energy = energy_value_field;
		next_done = 1'b0;
		sum_add = sum;
		cnt_add = cnt;
		rem_sh = {rem[14:0], quo[15]};
		quo_sh = {quo[14:0], 1'b0};
		unique case (state)
			RED_IDLE: begin
				// result simply stands here
			end
			RED_MEASURE: begin
				// fold in each fresh strength sample
				if (sample_pulse) begin
					sum_add = sum + {11'h000, strength};
					cnt_add = cnt + 8'h01;
				end
				next_sum = sum_add;
				next_cnt = cnt_add;
				next_win_cnt = win_cnt + 14'h0001;
				if (win_cnt >= win_len - 14'h0001) begin
					// scale by three so the result counts in dB steps
					next_state = RED_DIVIDE;
					next_rem = 16'h0000;
					next_step = 5'h00;
					if (cnt_add == 8'h00) begin
						// no sample landed in a short window: use the present one
						next_quo = ({11'h000, strength} << 1) + {11'h000, strength};
						next_den = 8'h01;
					end else begin
						next_quo = (sum_add << 1) + sum_add;
						next_den = cnt_add;
					end
				end
			end
			RED_DIVIDE: begin
				// one restoring step a cycle; far inside the 12us allowance
				if (rem_sh >= {8'h00, den}) begin
					rem_sh = rem_sh - {8'h00, den};
					quo_sh[0] = 1'b1;
				end
				next_rem = rem_sh;
				next_quo = quo_sh;
				next_step = step + 5'h01;
				if (step == red_pkg::DIV_STEPS - 5'h01) begin
					next_state = RED_IDLE;
					// clamp keeps codes 0x55 upward from ever appearing
					if (quo_sh > {8'h00, red_pkg::ENERGY_MAX}) begin
						next_energy = red_pkg::ENERGY_MAX;
					end else begin
						next_energy = quo_sh[7:0];
					end
					// only a manual request is announced
					next_done = manual_pend;
					next_manual_pend = 1'b0;
				end
			end
			default: begin
				next_state = RED_IDLE;
				next_manual_pend = 1'b0;
			end
		endcase
		// a new start restarts the window from any state
		if ((ed_write && manual_ok) || sync_accept) begin
			next_state = RED_MEASURE;
			next_win_cnt = 14'h0000;
			next_win_len = mode_win;
			next_sum = 16'h0000;
			next_cnt = 8'h00;
		end
		if (ed_write && manual_ok) begin
			next_manual_pend = 1'b1;
		end
		if (ed_write && !manual_ok) begin
			// answered at once, nothing measured, result untouched
			next_done = 1'b1;
		end
	end

	// register the sequencer; written data is never stored
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= RED_IDLE;
			win_cnt <= 14'h0000;
			win_len <= 14'h0001;
			sum <= 16'h0000;
			cnt <= 8'h00;
			quo <= 16'h0000;
			rem <= 16'h0000;
			den <= 8'h01;
			step <= 5'h00;
			manual_pend <= 1'b0;
			energy_value_field <= red_pkg::ENERGY_RESET;
			measurement_done_event_out <= 1'b0;
		end else begin
			state <= next_state;
			win_cnt <= next_win_cnt;
			win_len <= next_win_len;
			sum <= next_sum;
			cnt <= next_cnt;
			quo <= next_quo;
			rem <= next_rem;
			den <= next_den;
			step <= next_step;
			manual_pend <= next_manual_pend;
			energy_value_field <= next_energy;
			measurement_done_event_out <= next_done;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	AST_STRENGTH_MAX: assert property (strength <= red_pkg::STRENGTH_MAX)
		else $error("strength above 28");
	AST_ED_RANGE: assert property (
		energy_value_field <= red_pkg::ENERGY_MAX || energy_value_field == 8'hFF)
		else $error("energy code out of range");
	AST_MANUAL_REJECT_DONE: assert property (
		(ed_write && !manual_ok) |=> measurement_done_event_out && $stable(energy_value_field))
		else $error("rejected request not answered");
	AST_WRITE_NOT_STORED: assert property (
		(ed_write && state == RED_IDLE) |=> $stable(energy_value_field))
		else $error("written data stored in energy register");
	AST_AUTO_SILENT: assert property (
		(sync_accept && !manual_pend && !ed_write) |=> (!measurement_done_event_out)[*8])
		else $error("automatic measurement raised done");
	AST_PDT_DIS_BLOCKS: assert property (
		(preamble_detect_disable && sync_header_in && state == RED_IDLE && !ed_write)
		|=> state == RED_IDLE)
		else $error("header detected while disabled");
	AST_STATUS_WRITE_IGNORED: assert property (
		(status_write && state == RED_IDLE) |=> state == RED_IDLE && $stable(energy_value_field))
		else $error("status write had a side effect");
	AST_CRC_CLEAR: assert property (
		(sync_accept && !frame_end_event_in) |=> !crc_valid)
		else $error("check flag not cleared at header");
	AST_CRC_SET: assert property (
		(frame_end_event_in && fcs_ok_in) |=> crc_valid)
		else $error("check flag not set at frame end");
	AST_START_MEASURE: assert property (
		(ed_write && manual_ok) |=> state == RED_MEASURE && manual_pend)
		else $error("manual start not taken");
	AST_RESULT_LATENCY: assert property (
		(state == RED_DIVIDE && $past(state) == RED_MEASURE)
		|-> ##[1:20] (state != RED_DIVIDE))
		else $error("result slower than processing allowance");
	AST_HOLD: assert property (
		(state == RED_IDLE && $past(state) == RED_IDLE) |-> $stable(energy_value_field))
		else $error("energy changed without a measurement");

	COV_MANUAL_DONE: cover property (manual_pend ##1 measurement_done_event_out);
	COV_AUTO_DONE: cover property (sync_accept ##[1:1000] (state == RED_DIVIDE));
	COV_REJECT: cover property (ed_write && !manual_ok);
	COV_UNMAPPED: cover property (bus_setup ##1 pslverr_out);
endmodule : red_readout

// [testbench/tb_top.sv]
// self-checking testbench of the strength and energy readout
`timescale 1ns/10ps
`define CHK(got, exp) begin \
	checks++; \
	if ((got) !== (exp)) begin \
		failures++; \
		$display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
	end \
end
module tb_top;
	// short energy windows keep the run brief; expectations derive from them
	localparam logic [13:0] WIN_B20 = 14'h0028;
	localparam logic [13:0] WIN_B40 = 14'h001E;
	localparam logic [13:0] WIN_OQ = 14'h0014;
	localparam logic [13:0] WIN_HDR = 14'h000A;
	logic clk_in, rst_in, psel_in, penable_in, pwrite_in;
	logic [7:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out;
	logic pready_out, pslverr_out;
	logic [1:0] phy_mode_in, random_bits_in;
	logic rx_listen_in, rx_busy_in, auto_ack_receive_state_in;
	logic [7:0] rf_level_in;
	logic sync_header_in, frame_end_event_in, fcs_ok_in;
	logic measurement_done_event_out, sync_accept_out;
	int failures, checks, done_cnt, acc_cnt, n, c0;
	logic [7:0] seed, e_last;
	logic [31:0] rd;
	logic err;
	// awkward input powers: floor, step edges, saturation edge, top
	logic [7:0] corner [4] = '{8'h00, 8'h03, 8'h56, 8'h57};

	red_readout #(.ED_WIN_BPSK20(WIN_B20), .ED_WIN_BPSK40(WIN_B40), .ED_WIN_OQPSK(WIN_OQ),
		.ED_WIN_HDR(WIN_HDR)) red_readout_inst (.clk_in(clk_in), .rst_in(rst_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out), .phy_mode_in(phy_mode_in),
		.rx_listen_in(rx_listen_in), .rx_busy_in(rx_busy_in),
		.auto_ack_receive_state_in(auto_ack_receive_state_in), .rf_level_in(rf_level_in),
		.sync_header_in(sync_header_in), .frame_end_event_in(frame_end_event_in),
		.fcs_ok_in(fcs_ok_in), .random_bits_in(random_bits_in),
		.measurement_done_event_out(measurement_done_event_out),
		.sync_accept_out(sync_accept_out));

	// 25 MHz clock
	always #20 clk_in = ~clk_in;

	// pulse counters sample away from the launching edge
	always @(negedge clk_in) begin
		if (measurement_done_event_out === 1'b1) done_cnt++;
		if (sync_accept_out === 1'b1) acc_cnt++;
	end

	// random source for input powers and live random bits
	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction : lfsr

	// strength from power above floor: 3 dB steps, saturating at 87 dB
	function automatic logic [4:0] exp_str(input logic [7:0] rf);
		if (rf >= 8'h57) return 5'h1C;
		return 5'(rf / 8'h03);
	endfunction : exp_str

	// energy for a steady strength: three codes per strength step, capped
	function automatic logic [7:0] exp_ed(input logic [4:0] s);
		logic [7:0] e;
		e = 8'(s) * 8'h03;
		return (e > 8'h54) ? 8'h54 : e;
	endfunction : exp_ed

	// energy window length in cycles per mode
	function automatic int win(input logic [1:0] m);
		case (m)
			2'h0: return int'(WIN_B20);
			2'h1: return int'(WIN_B40);
			2'h2: return int'(WIN_OQ);
			default: return int'(WIN_HDR);
		endcase
	endfunction : win

	// strength refresh interval in cycles per mode
	function automatic int refr(input logic [1:0] m);
		if (m == 2'h0) return red_pkg::REFRESH_CYC_BPSK20;
		if (m == 2'h1) return red_pkg::REFRESH_CYC_BPSK40;
		return red_pkg::REFRESH_CYC_OQPSK;
	endfunction : refr

	// status word as software should see it
	function automatic logic [31:0] stat(input logic crc, input logic [4:0] s);
		return {24'h000000, crc, random_bits_in, s};
	endfunction : stat

	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		// wait states are allowed: only the hang guard ends a stuck transfer
		do begin
			@(posedge clk_in);
		end while (pready_out !== 1'b1);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb

	// read a register and compare the whole word
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		`CHK(rd, e)
	endtask : rd_chk

	// count cycles until a done pulse, giving up at the limit
	task automatic wait_done(input int lim);
		c0 = done_cnt;
		n = 0;
		while (done_cnt == c0 && n < lim) begin
			@(negedge clk_in);
			n++;
		end
	endtask : wait_done

	// one-cycle pulse on the header or frame end input
	task automatic pulse(input logic hdr);
		@(posedge clk_in);
		if (hdr) sync_header_in <= 1'b1;
		else frame_end_event_in <= 1'b1;
		@(posedge clk_in);
		sync_header_in <= 1'b0;
		frame_end_event_in <= 1'b0;
	endtask : pulse

	// hang guard: the whole run needs about 9000 cycles
	initial begin
		#(40 * 60000);
		failures++;
		results();
	end

	// verdict and end of run
	task automatic results;
		if (failures == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : results

	initial begin
		{clk_in, psel_in, penable_in, pwrite_in, sync_header_in, frame_end_event_in} = '0;
		{rx_listen_in, rx_busy_in, auto_ack_receive_state_in, fcs_ok_in} = '0;
		{paddr_in, pwdata_in, rf_level_in, random_bits_in} = '0;
		phy_mode_in = 2'h2;
		rst_in = 1'b1;
		seed = 8'h08;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		// reset contents and an unmapped word
		rd_chk(8'h18, 32'h00000000);
		rd_chk(8'h1C, 32'h000000FF);
		apb(1'b0, 8'h20, 32'h00000000);
		`CHK(err, 1'b1)
		// strength and manual energy in every mode, listening and busy in turn
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			phy_mode_in <= 2'(i);
			rx_listen_in <= i[0];
			rx_busy_in <= ~i[0];
			repeat (refr(2'(i)) + 5) @(posedge clk_in);
			rf_level_in <= (i < 4) ? corner[i] : seed;
			random_bits_in <= seed[1:0];
			repeat (refr(2'(i)) + 5) @(posedge clk_in);
			rd_chk(8'h18, stat(1'b0, exp_str(rf_level_in)));
			apb(1'b1, 8'h1C, {4{seed}});
			wait_done(win(2'(i)) + 60);
			`CHK(n >= win(2'(i)) && n <= win(2'(i)) + 40, 1'b1)
			e_last = exp_ed(exp_str(rf_level_in));
			rd_chk(8'h1C, {24'h000000, e_last});
		end
		// manual request outside receive: done at once, nothing measured
		rx_listen_in <= 1'b0;
		rx_busy_in <= 1'b0;
		rf_level_in <= ~rf_level_in;
		apb(1'b1, 8'h1C, 32'h00000000);
		wait_done(20);
		`CHK(n <= 3, 1'b1)
		repeat (220) @(posedge clk_in);
		rd_chk(8'h1C, {24'h000000, e_last});
		rd_chk(8'h18, stat(1'b0, exp_str(~rf_level_in)));
		// auto-ack receive state refuses as well
		rx_listen_in <= 1'b1;
		auto_ack_receive_state_in <= 1'b1;
		apb(1'b1, 8'h1C, 32'hFFFFFFFF);
		wait_done(20);
		`CHK(n <= 3, 1'b1)
		rd_chk(8'h1C, {24'h000000, e_last});
		auto_ack_receive_state_in <= 1'b0;
		// writes to the status word start nothing: no done pulse within 60 cycles
		apb(1'b1, 8'h18, 32'hFFFFFFFF);
		wait_done(60);
		`CHK(n, 60)
		// header detection blocked while the disable bit is set
		apb(1'b1, 8'h54, 32'hFFFFFFFF);
		rd_chk(8'h54, 32'h00000080);
		c0 = acc_cnt;
		pulse(1'b1);
		repeat (40) @(posedge clk_in);
		`CHK(acc_cnt, c0)
		rd_chk(8'h1C, {24'h000000, e_last});
		apb(1'b1, 8'h54, 32'h00000000);
		// frame check flag, then a silent automatic measurement in high rate mode
		phy_mode_in <= 2'h3;
		rf_level_in <= 8'h2D;
		repeat (410) @(posedge clk_in);
		fcs_ok_in <= 1'b1;
		pulse(1'b0);
		fcs_ok_in <= 1'b0;
		rd_chk(8'h18, stat(1'b1, 5'h0F));
		c0 = acc_cnt;
		n = done_cnt;
		pulse(1'b1);
		repeat (win(2'h3) + 30) @(posedge clk_in);
		`CHK(acc_cnt, c0 + 1)
		`CHK(done_cnt, n)
		rd_chk(8'h1C, 32'h0000002D);
		rd_chk(8'h18, stat(1'b0, 5'h0F));
		// result holds while power moves and no new start comes
		rf_level_in <= 8'h00;
		repeat (410) @(posedge clk_in);
		rd_chk(8'h1C, 32'h0000002D);
		results();
	end
endmodule : tb_top
